// [design/ccd_exec_map.vh]
// ccd_exec_map.vh: register map, opcode masks and field positions
// assumes: included by the executor, 32-bit AHB-Lite data, word access
`ifndef CCD_EXEC_MAP_VH
`define CCD_EXEC_MAP_VH

// ****************************************************
// register byte offsets (haddr[9:0])
// ****************************************************
`define CCD_R_INSTR 10'h000
`define CCD_R_ACC 10'h004
`define CCD_R_STATUS 10'h008
`define CCD_R_PC 10'h00C
`define CCD_R_PAGE 10'h010
`define CCD_R_STKTOP 10'h014
`define CCD_R_WDOG 10'h018
`define CCD_R_INFO 10'h01C
`define CCD_R_CYCLES 10'h020
// file window: byte offset 0x200 + 4*f, f in 0..127
`define CCD_FILE_SEL 9
`define CCD_FILE_HI 8
`define CCD_FILE_LO 2

// ****************************************************
// status bit positions
// ****************************************************
`define CCD_ST_Z 2
`define CCD_ST_PWRDN 3
`define CCD_ST_TMOUT 4

// ****************************************************
// instruction word fields
// ****************************************************
`define CCD_IW 14
`define CCD_OP_WDCLR 14'h0064
`define CCD_CALL_HI 13
`define CCD_CALL_LO 11
`define CCD_CALL_CODE 3'h4
`define CCD_OP_HI 13
`define CCD_OP_LO 8
`define CCD_OP_CPL 6'h09
`define CCD_OP_DEC 6'h03
`define CCD_OP_DECSKIP 6'h0B
`define CCD_OP_CLR 6'h01
`define CCD_DEST_BIT 7
`define CCD_FA_HI 6
`define CCD_K_HI 10
`define CCD_PG_HI 4
`define CCD_PG_LO 3

// ****************************************************
// sizes and constants
// ****************************************************
`define CCD_PCW 13
`define CCD_SPW 3
`define CCD_STK_DEPTH 8
`define CCD_FILE_DEPTH 128
`define CCD_ZERO8 8'h00
`define CCD_ONE8 8'h01
`define CCD_PC_ONE 13'h0001
`define CCD_SP_ONE 3'h1
`define CCD_CYC_ONE 16'h0001
`define CCD_CYC_TWO 16'h0002
`define CCD_PRE_ONE 8'h01
`define CCD_PRE_TOP 8'hFF
`define CCD_CYC_ZERO 16'h0000
`define CCD_ADDR_ZERO 10'h000
`define CCD_WORD_ZERO 32'h0000_0000

`endif

// [design/ccd_exec.v]
// ccd_exec.v: instruction executor for watchdog clear, call, complement,
// clear, decrement and decrement-skip, with its AHB-Lite register slave
// assumes: single slave on the bus, word transfers only, hclk 200 MHz
// assumes: file memory and return stack are not reset; write before reading
//
// Notes on behaviour
// - watchdog clear zeroes the watchdog counter and its prescaler.
// - watchdog clear sets timeout and powerdown flags; other flags stay.
// - call pushes program counter plus one onto the return stack top.
// - call loads pc[10:0] from immediate, pc[12:11] from page latch [4:3].
// - call takes an 11-bit target, two cycles, no flag change.
// - complement inverts addressed file register; only zero flag updates.
// - destination bit 0 stores to accumulator, 1 back to file register.
// - clear-file writes 00h to the file register and sets zero flag.
// - decrement subtracts one, stores to destination, updates zero flag only.
// - clear-accumulator writes 00h to accumulator and sets zero flag.
// - decrement-skip subtracts one into destination, no flag change.
// - zero decrement-skip result discards next instruction as a no-op.
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "ccd_exec_map.vh"

module ccd_exec (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata
);

  // ****************************************************
  // bus data phase tracking
  // ****************************************************
  reg dp_valid_q;
  reg dp_wr_q;
  reg [9:0] dp_addr_q;
  reg rd_done_q;

  // reads take one wait state so a write in the previous data
  // phase is always visible to the read that follows it
  assign hreadyout = ~(dp_valid_q & ~dp_wr_q & ~rd_done_q);
  assign hresp = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_q <= 1'b0;
      dp_wr_q <= 1'b0;
      dp_addr_q <= `CCD_ADDR_ZERO;
      rd_done_q <= 1'b0;
    end else begin
      rd_done_q <= dp_valid_q & ~dp_wr_q & ~rd_done_q;
      if (hready) begin
        dp_valid_q <= hsel & htrans[1];
        dp_wr_q <= hwrite;
        dp_addr_q <= haddr[9:0];
      end
    end
  end

  wire wr_go = dp_valid_q & dp_wr_q;
  wire rd_go = dp_valid_q & ~dp_wr_q & ~rd_done_q;
  wire is_file = dp_addr_q[`CCD_FILE_SEL];
  wire [6:0] bus_fa = dp_addr_q[`CCD_FILE_HI:`CCD_FILE_LO];

  // ****************************************************
  // core state
  // ****************************************************
  reg [7:0] file_mem [0:`CCD_FILE_DEPTH-1];
  reg [`CCD_PCW-1:0] stk_mem [0:`CCD_STK_DEPTH-1];
  reg [7:0] acc_q;
  reg z_q;
  reg pwrdn_n_q;
  reg tmout_n_q;
  reg [`CCD_PCW-1:0] pc_q;
  reg [7:0] page_q;
  reg [`CCD_SPW-1:0] sp_q;
  reg skip_q;
  reg [7:0] wdog_q;
  reg [7:0] pre_q;
  reg [15:0] cyc_q;
  reg [`CCD_IW-1:0] last_ins_q;

  // ****************************************************
  // decode
  // ****************************************************
  wire exec = wr_go & ~is_file & (dp_addr_q == `CCD_R_INSTR);
  wire [`CCD_IW-1:0] ins = hwdata[`CCD_IW-1:0];
  wire [5:0] op = ins[`CCD_OP_HI:`CCD_OP_LO];
  wire dest = ins[`CCD_DEST_BIT];
  wire [6:0] fa = ins[`CCD_FA_HI:0];
  wire [7:0] fval = file_mem[fa];
  wire is_wdc = (ins == `CCD_OP_WDCLR);
  wire is_call = (ins[`CCD_CALL_HI:`CCD_CALL_LO] == `CCD_CALL_CODE);
  wire is_complement_file_op = (op == `CCD_OP_CPL);
  wire is_decrement_file_op = (op == `CCD_OP_DEC);
  wire is_dsz = (op == `CCD_OP_DECSKIP);
  wire is_clear_file_op = (op == `CCD_OP_CLR) & dest;
  wire is_clear_accumulator_op = (op == `CCD_OP_CLR) & ~dest;
  // a pending skip turns the fetched word into a no-op
  wire run = exec & ~skip_q;
  wire [`CCD_PCW-1:0] pc_next = pc_q + `CCD_PC_ONE;

  reg [7:0] res;
  reg wr_f;
  reg wr_w;
  reg upd_z;

  always @* begin
    res = `CCD_ZERO8;
    wr_f = 1'b0;
    wr_w = 1'b0;
    upd_z = 1'b0;
    if (is_complement_file_op) begin
      res = ~fval;
      wr_f = dest;
      wr_w = ~dest;
      upd_z = 1'b1;
    end else if (is_decrement_file_op || is_dsz) begin
      res = fval - `CCD_ONE8;
      wr_f = dest;
      wr_w = ~dest;
      upd_z = is_decrement_file_op;
    end else if (is_clear_file_op) begin
      wr_f = 1'b1;
      upd_z = 1'b1;
    end else if (is_clear_accumulator_op) begin
      wr_w = 1'b1;
      upd_z = 1'b1;
    end
  end

  wire res_zero = (res == `CCD_ZERO8);

  // ****************************************************
  // file registers and return stack (no reset on arrays)
  // ****************************************************
  always @(posedge hclk) begin
    if (wr_go && is_file) begin
      file_mem[bus_fa] <= hwdata[7:0];
    end else if (run && wr_f) begin
      file_mem[fa] <= res;
    end
    if (run && is_call) begin
      stk_mem[sp_q] <= pc_next;
    end
  end

  // ****************************************************
  // watchdog counter and prescaler
  // ****************************************************
  // free-running: the prescaler wraps into the counter; there is no
  // time-out action here, software only observes the count
  wire wdc_run = run & is_wdc;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdog_q <= `CCD_ZERO8;
      pre_q <= `CCD_ZERO8;
    end else if (wdc_run) begin
      // clear wins over a wrap falling in the same cycle
      wdog_q <= `CCD_ZERO8;
      pre_q <= `CCD_ZERO8;
    end else begin
      pre_q <= pre_q + `CCD_PRE_ONE;
      if (pre_q == `CCD_PRE_TOP) begin
        wdog_q <= wdog_q + `CCD_ONE8;
      end
    end
  end

  // ****************************************************
  // status flags
  // ****************************************************
  // flags move only on a running word or a status write
  wire sw_wr = wr_go & ~is_file;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      z_q <= 1'b0;
      pwrdn_n_q <= 1'b1;
      tmout_n_q <= 1'b1;
    end else if (run) begin
      if (upd_z) begin
        z_q <= res_zero;
      end
      if (is_wdc) begin
        tmout_n_q <= 1'b1;
        pwrdn_n_q <= 1'b1;
      end
    end else if (sw_wr && (dp_addr_q == `CCD_R_STATUS)) begin
      z_q <= hwdata[`CCD_ST_Z];
      pwrdn_n_q <= hwdata[`CCD_ST_PWRDN];
      tmout_n_q <= hwdata[`CCD_ST_TMOUT];
    end
  end

  // ****************************************************
  // accumulator
  // ****************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= `CCD_ZERO8;
    end else if (run && wr_w) begin
      acc_q <= res;
    end else if (sw_wr && (dp_addr_q == `CCD_R_ACC)) begin
      acc_q <= hwdata[7:0];
    end
  end

  // ****************************************************
  // program counter, page latch, stack pointer and skip
  // ****************************************************
  // the pointer wraps after eight pushes; deeper nesting
  // silently overwrites the oldest return address
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_q <= {`CCD_PCW{1'b0}};
      page_q <= `CCD_ZERO8;
      sp_q <= {`CCD_SPW{1'b0}};
      skip_q <= 1'b0;
      last_ins_q <= {`CCD_IW{1'b0}};
    end else begin
      if (exec) begin
        last_ins_q <= ins;
      end
      if (exec && skip_q) begin
        // discarded word: costs the second cycle and one pc step
        skip_q <= 1'b0;
        pc_q <= pc_next;
      end else if (run) begin
        if (is_call) begin
          // only two page bits take part, the rest of the latch is spare
          sp_q <= sp_q + `CCD_SP_ONE;
          pc_q <= {page_q[`CCD_PG_HI:`CCD_PG_LO],
                   ins[`CCD_K_HI:0]};
        end else begin
          pc_q <= pc_next;
        end
        if (is_dsz && res_zero) begin
          skip_q <= 1'b1;
        end
      end else if (sw_wr) begin
        case (dp_addr_q)
          `CCD_R_PC: begin
            pc_q <= hwdata[`CCD_PCW-1:0];
          end
          `CCD_R_PAGE: begin
            page_q <= hwdata[7:0];
          end
          `CCD_R_INFO: begin
            skip_q <= 1'b0;
          end
          default: begin
            skip_q <= skip_q;
          end
        endcase
      end
    end
  end

  // ****************************************************
  // instruction cycle counter
  // ****************************************************
  // 16 bits wrap silently; software should read differences
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_q <= `CCD_CYC_ZERO;
    end else if (run && is_call) begin
      cyc_q <= cyc_q + `CCD_CYC_TWO;
    end else if (exec) begin
      cyc_q <= cyc_q + `CCD_CYC_ONE;
    end
  end

  // ****************************************************
  // read mux, registered into hrdata
  // ****************************************************
  // a stack read before any call returns an unwritten entry
  wire [`CCD_SPW-1:0] sp_top = sp_q - `CCD_SP_ONE;
  reg [31:0] rd_val;

  always @* begin
    rd_val = `CCD_WORD_ZERO;
    if (is_file) begin
      rd_val[7:0] = file_mem[bus_fa];
    end else begin
      case (dp_addr_q)
        `CCD_R_INSTR: begin
          rd_val[`CCD_IW-1:0] = last_ins_q;
        end
        `CCD_R_ACC: begin
          rd_val[7:0] = acc_q;
        end
        `CCD_R_STATUS: begin
          rd_val[`CCD_ST_Z] = z_q;
          rd_val[`CCD_ST_PWRDN] = pwrdn_n_q;
          rd_val[`CCD_ST_TMOUT] = tmout_n_q;
        end
        `CCD_R_PC: begin
          rd_val[`CCD_PCW-1:0] = pc_q;
        end
        `CCD_R_PAGE: begin
          rd_val[7:0] = page_q;
        end
        `CCD_R_STKTOP: begin
          rd_val[`CCD_PCW-1:0] = stk_mem[sp_top];
        end
        `CCD_R_WDOG: begin
          rd_val[15:0] = {pre_q, wdog_q};
        end
        `CCD_R_INFO: begin
          rd_val[3:0] = {sp_q, skip_q};
        end
        `CCD_R_CYCLES: begin
          rd_val[15:0] = cyc_q;
        end
        default: begin
          rd_val = `CCD_WORD_ZERO;
        end
      endcase
    end
  end

  // held between reads so a late sampler still sees the last word
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `CCD_WORD_ZERO;
    end else if (rd_go) begin
      hrdata <= rd_val;
    end
  end

endmodule

// [tb/ccd_exec_assertions.sv]
// ccd_exec_assertions.sv: bus and instruction checks on ccd_exec ports
// assumes: one master, hready tied to hreadyout, no pipelined requests
`timescale 1ns/1ps
module ccd_exec_chk (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata
);
  // ****
  // data-phase tracking
  // ****
  reg ap_q, aw_q, iv_q;
  reg [9:0] aa_q;
  reg [13:0] li_q;
  wire rdp = ap_q && !aw_q && hreadyout;
  wire req = hsel && htrans[1] && hready;
  // status read with the last state change made by an instruction word
  wire lst = rdp && iv_q && aa_q == 10'h008;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= 1'h0;
      aw_q <= 1'h0;
      iv_q <= 1'h0;
      aa_q <= 10'h0;
      li_q <= 14'h0;
    end else begin
      if (hready) begin
        ap_q <= req;
        aw_q <= hwrite;
        aa_q <= haddr[9:0];
      end
      if (hready && ap_q && aw_q) begin
        if (aa_q == 10'h000) begin
          iv_q <= 1'h1;
          li_q <= hwdata[13:0];
        end else if (aa_q[9] || aa_q < 10'h014 || aa_q == 10'h01C) begin
          iv_q <= 1'h0;
        end
      end
    end
  end
  // ****
  // checks
  // ****
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_okay_resp: assert property (hresp == 1'h0) else $error("non-okay response");
  a_read_wait: assert property (req && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_fast: assert property (req && hwrite |=> hreadyout) else $error("write stalled");
  a_rdata_hold: assert property (!(ap_q && !aw_q) |=> $stable(hrdata))
    else $error("read data moved");
  a_wdc_flags: assert property (lst && li_q == 14'h0064 |-> hrdata[4:3] == 2'h3)
    else $error("flags not set by watchdog clear");
  a_clear_file_op_zero: assert property (lst && li_q[13:7] == 7'h03 |-> hrdata[2])
    else $error("zero flag low after file clear");
  a_clra_zero: assert property (lst && li_q == 14'h0100 |-> hrdata[2])
    else $error("zero flag low after accumulator clear");
  a_pc_width: assert property (rdp && aa_q == 10'h00C |-> hrdata[31:13] == 19'h0)
    else $error("counter wider than 13 bits");
  c_wdc_read: cover property (lst && li_q == 14'h0064);
  c_read: cover property (req && !hwrite);
  c_pc_read: cover property (rdp && aa_q == 10'h00C);
endmodule
bind ccd_exec ccd_exec_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

// [tb/tb_clear_call_dec_exec.sv]
// tb_clear_call_dec_exec.sv: self-checking bench for ccd_exec
// assumes: checker bound separately, bus master is this bench alone
`timescale 1ns/1ps
module tb_clear_call_dec_exec;
  typedef struct {logic [9:0] a; logic [15:0] d; logic [9:0] r; logic [7:0] m, e;} ccd_row_t;
  reg hclk, hresetn, hsel, hwrite;
  reg [31:0] haddr, hwdata;
  reg [1:0] htrans;
  wire hready;
  wire [31:0] hrdata;
  int miscompares, check_count, ncyc, tick;
  logic [31:0] rv;
  ccd_row_t rows [20];
  ccd_exec dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(), .hrdata(hrdata));
  initial begin
    hclk = 1'h0;
    forever #2.5 hclk = ~hclk;
  end
  // ****
  // bus tasks
  // ****
  // called just after a rising edge; ready and read data are taken at rising edges
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
    haddr <= {22'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hready !== 1'h1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    if (w && a == 10'h000) ncyc += (d[13:11] == 3'h4) ? 2 : 1;
    @(posedge hclk);
    while (hready !== 1'h1) @(posedge hclk);
    rv = hrdata;
  endtask
  task automatic chk(input logic [9:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    check_count++;
    if ((rv & m) !== e) begin
      miscompares++;
      $display("[ERR] t=%0t a=%h got=%h exp=%h", $time, a, rv & m, e);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge hclk) begin
    tick++;
    if (tick == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  // ****
  // stimulus
  // ****
  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    hwrite = 1'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    // 0x100 is unmapped: a write there changes nothing
    rows = '{'{10'h214, 16'h5A, 10'h214, 8'hFF, 8'h5A}, '{10'h0, 16'h985, 10'h214, 8'hFF, 8'hA5},
      '{10'h0, 16'h905, 10'h4, 8'hFF, 8'h5A}, '{10'h100, 16'h0, 10'h8, 8'h4, 8'h0},
      '{10'h0, 16'h100, 10'h4, 8'hFF, 8'h0}, '{10'h100, 16'h0, 10'h8, 8'h4, 8'h4},
      '{10'h0, 16'h385, 10'h214, 8'hFF, 8'hA4}, '{10'h100, 16'h0, 10'h8, 8'h4, 8'h0},
      '{10'h0, 16'h185, 10'h214, 8'hFF, 8'h0}, '{10'h100, 16'h0, 10'h8, 8'h4, 8'h4},
      '{10'h8, 16'h18, 10'h8, 8'h1C, 8'h18}, '{10'h3FC, 16'h1, 10'h3FC, 8'hFF, 8'h1},
      '{10'h0, 16'h37F, 10'h4, 8'hFF, 8'h0}, '{10'h100, 16'h0, 10'h8, 8'h4, 8'h4},
      '{10'h100, 16'h0, 10'h3FC, 8'hFF, 8'h1}, '{10'h8, 16'h0, 10'h8, 8'h1C, 8'h0},
      '{10'h3FC, 16'h3, 10'h3FC, 8'hFF, 8'h3}, '{10'h0, 16'hBFF, 10'h3FC, 8'hFF, 8'h2},
      '{10'h100, 16'h0, 10'h8, 8'h1C, 8'h0}, '{10'h0, 16'h64, 10'h8, 8'h1C, 8'h18}};
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    hsel <= 1'h1;
    @(posedge hclk);
    chk(10'h008, 32'h1C, 32'h18);
    $display("test reset done");
    foreach (rows[i]) begin
      xfer(1'h1, rows[i].a, {16'h0, rows[i].d});
      chk(rows[i].r, {24'h0, rows[i].m}, {24'h0, rows[i].e});
    end
    $display("test rows done");
    // let the watchdog counter move off zero before clearing it
    repeat (600) @(posedge hclk);
    xfer(1'h1, 10'h008, 32'h4);
    xfer(1'h1, 10'h000, 32'h64);
    chk(10'h008, 32'h1C, 32'h1C);
    chk(10'h018, 32'hF0FF, 32'h0);
    $display("test watchdog done");
    xfer(1'h1, 10'h010, 32'h18);
    xfer(1'h1, 10'h00C, 32'h123);
    xfer(1'h1, 10'h000, 32'h27FF);
    chk(10'h00C, 32'h1FFF, 32'h1FFF);
    chk(10'h014, 32'h1FFF, 32'h124);
    chk(10'h008, 32'h1C, 32'h1C);
    xfer(1'h1, 10'h010, 32'h10);
    xfer(1'h1, 10'h000, 32'h2000);
    chk(10'h00C, 32'h1FFF, 32'h1000);
    chk(10'h020, 32'hFFFF, 32'(ncyc));
    $display("test call done");
    xfer(1'h1, 10'h004, 32'h77);
    xfer(1'h1, 10'h3FC, 32'h1);
    xfer(1'h1, 10'h00C, 32'h50);
    xfer(1'h1, 10'h000, 32'hBFF);
    chk(10'h3FC, 32'hFF, 32'h0);
    chk(10'h01C, 32'h1, 32'h1);
    xfer(1'h1, 10'h000, 32'h100);
    chk(10'h004, 32'hFF, 32'h77);
    chk(10'h00C, 32'h1FFF, 32'h52);
    chk(10'h01C, 32'h1, 32'h0);
    chk(10'h020, 32'hFFFF, 32'(ncyc));
    chk(10'h100, 32'hFFFFFFFF, 32'h0);
    $display("test skip done");
    print_verdict();
  end
endmodule
